// *** hw/sss_pkg.sv ***
// sleep state sequencer constants, state and carrier types
package sss_pkg;

  // base time figures
  localparam int unsigned SYS_PERIOD_NS   = 5;       // clk_sys period
  localparam int unsigned RTC_PERIOD_US   = 32;      // internal real-time tick period, nominal
  localparam int unsigned BUS_PERIOD_NS   = 30;      // 33 MHz bus clock period, nominal
  localparam int unsigned RELEASE_MAX_MS  = 110;     // resume release to soft-off release, longest
  localparam int unsigned RELEASE_MAX_CYC = (RELEASE_MAX_MS * 1000000) / SYS_PERIOD_NS;

  // tick counts, in real-time ticks unless noted
  localparam logic [7:0] CNT_STRAP     = 8'h23;      // 35 ticks, lands in 32..38 periods
  localparam logic [7:0] CNT_PLT       = 8'h03;      // 3 ticks, lands in 2..3 periods
  localparam logic [7:0] CNT_SUS       = 8'h03;      // 3 ticks, at least 2 periods
  localparam logic [7:0] CNT_RST       = 8'h0A;      // 10 ticks, inside 7..17 periods
  localparam logic [7:0] CNT_STEP      = 8'h02;      // 2 ticks, lands in 1..2 periods
  localparam logic [7:0] CNT_OFF_WAKE  = 8'h05;      // 5 ticks, inside 1..10 periods
  localparam logic [7:0] CNT_RAM_WAKE  = 8'h01;      // 1 tick, as soon as possible
  localparam logic [7:0] CNT_RAM_REL   = 8'h02;      // 2 ticks, 1..4 periods when not stretched
  localparam logic [7:0] CNT_WIDTH_MIN = 8'h02;      // hibernate release without stretch
  localparam logic [7:0] CNT_GRANT_BUS = 8'h3E;      // 62 bus ticks, lands in 60..63 periods
  localparam logic [7:0] CNT_WAKE_BUS  = 8'h02;      // 2 bus ticks, inside 1..25 periods
  localparam logic [7:0] CNT_EXIT_BUS  = 8'h09;      // 9 bus ticks, at least 8 periods

  // register map, byte addresses
  localparam logic [3:0] ADDR_CTRL   = 4'h0;         // configuration
  localparam logic [3:0] ADDR_CMD    = 4'h4;         // sleep request
  localparam logic [3:0] ADDR_STATUS = 4'h8;         // sequencer status, read only

  // control field positions and reset value
  localparam int unsigned CTRL_APL_BIT     = 0;      // stay off after power loss
  localparam int unsigned CTRL_STRETCH_BIT = 3;      // hibernate assertion stretch enable
  localparam int unsigned CTRL_WIDTH_LSB   = 4;      // minimum assertion width, two bits
  localparam logic [5:0]  CTRL_RESET       = 6'h00;

  // requested sleep targets
  localparam logic [2:0] TGT_LIGHT = 3'h1;
  localparam logic [2:0] TGT_RAM   = 3'h2;
  localparam logic [2:0] TGT_HIB   = 3'h3;
  localparam logic [2:0] TGT_OFF   = 3'h4;

  // sequencer states, one hot
  typedef enum logic [18:0] {
    ST_OFF      = 19'h00001,
    ST_OFF_WAKE = 19'h00002,
    ST_HIB_REL  = 19'h00004,
    ST_RAM_REL  = 19'h00008,
    ST_PWR_WAIT = 19'h00010,
    ST_STRAP    = 19'h00020,
    ST_PLT      = 19'h00040,
    ST_ON       = 19'h00080,
    ST_GRANT    = 19'h00100,
    ST_S1_PEND  = 19'h00200,
    ST_S1       = 19'h00400,
    ST_S1_WAKE  = 19'h00800,
    ST_S1_EXIT  = 19'h01000,
    ST_SUS_PEND = 19'h02000,
    ST_RST_PEND = 19'h04000,
    ST_RAM_PEND = 19'h08000,
    ST_RAM      = 19'h10000,
    ST_RAM_WAKE = 19'h20000,
    ST_HIB      = 19'h40000
  } sss_state_type;

  // platform control pins, all active low
  typedef struct packed {
    logic suspend_status_n;
    logic platform_reset_n;
    logic sleep_ram_n;
    logic sleep_hibernate_n;
    logic sleep_softoff_n;
    logic stop_clock_n;
    logic processor_sleep_n;
  } sss_pins_type;

  localparam sss_pins_type PINS_RESET = 7'h03;       // off: all asserted, processor pins idle

endpackage

// *** hw/sss_sequencer.sv ***
// sleep state and platform reset sequencer
// What this block does
// - latch straps, release suspend status 32..38 ticks
// - release platform reset 2..3 ticks later
// - after resume reset, clock runs, soft-off releases
// - power-loss bit holds soft-off until wake
// - ram release 1..4 ticks after hibernate
// - light-sleep wake releases processor sleep quickly
// - processor sleep 60..63 bus ticks after grant
// - suspend status at least 2 ticks after grant
// - resets assert 7..17 ticks after suspend status
// - ram sleep 1..2 ticks after resets
// - hibernate sleep 1..2 ticks after ram
// - soft-off sleep 1..2 ticks after hibernate
// - button override asserts all sleep levels together
// - soft-off wake releases in 1..10 ticks
// - ram wake releases as fast as possible
// - hibernate release follows width and stretch bits
// - stop clock releases 9 bus ticks later
// - thermal trip asserts sleep levels within 3
// - assert stop clock, wait for grant message
// - engine sleep moves with ram sleep
// - tick delays counted on real-time clock
// - bus delays counted on bus clock
module sss_sequencer #(
  parameter int unsigned RELEASE_LIMIT = sss_pkg::RELEASE_MAX_CYC  // soft-off release bound, cycles
) (
  input  wire logic        clk_sys,              // 200 MHz system clock
  input  wire logic        rstn,                 // synchronous reset, active low
  input  wire logic        resume_well_reset_n,  // resume well reset pin
  input  wire logic        core_power_good,      // core rails good pin
  input  wire logic        regulator_power_good, // processor regulator good pin
  input  wire logic        thermal_trip_n,       // thermal trip pin
  input  wire logic        power_button_ovr_n,   // power button override pin
  input  wire logic        wake_event_n,         // wake event pin
  input  wire logic        rtc_tick,             // internal real-time clock pin
  input  wire logic        bus_clock,            // 33 MHz bus clock pin
  input  wire logic [3:0]  strap_pins,           // processor interface straps
  input  wire logic        stop_grant_msg,       // grant message pulse from host link
  input  wire logic [3:0]  addr,                 // register byte address
  input  wire logic [31:0] wr_data,              // register write data
  input  wire logic        wr_en,                // write strobe
  input  wire logic        rd_en,                // read strobe
  output logic      [31:0] rd_data,              // read data, cycle after strobe
  output logic             suspend_status_n,     // suspend status
  output logic             platform_reset_n,     // platform reset
  output logic             bus_reset_n,          // bus reset
  output logic             sleep_ram_n,          // suspend-to-ram sleep
  output logic             sleep_hibernate_n,    // hibernate sleep
  output logic             sleep_softoff_n,      // soft-off sleep
  output logic             sleep_mgmt_engine_n,  // management engine sleep
  output logic             processor_sleep_n,    // processor sleep
  output logic             stop_clock_n,         // processor stop clock
  output logic             suspend_clock,        // suspend clock
  output logic      [3:0]  strap_value,          // latched straps
  output logic             strap_capture         // one-cycle pulse on strap latch
);

  // pin synchronisers: stage one read only by stage two
  logic [10:0] sync_a;                 // first stage
  logic [10:0] sync_b;                 // second stage
  logic        rtc_prev;               // tick edge history
  logic        bus_prev;               // bus clock edge history
  logic        rtc_pulse;              // one real-time tick
  logic        bus_pulse;              // one bus clock tick
  logic        rw_ok;                  // resume well out of reset
  logic        pg_ok;                  // both power goods
  logic        trip;                   // thermal trip active
  logic        ovr;                    // button override active
  logic        wake;                   // wake event active
  logic [3:0]  strap_s;                // synced straps

  // control state
  sss_pkg::sss_state_type state;       // current state
  sss_pkg::sss_state_type next_state;  // next state
  logic [7:0]  cnt;                    // ticks spent in state
  logic        tick;                   // tick that this state counts
  logic [7:0]  width;                  // hibernate release count
  logic [5:0]  ctrl;                   // configuration register
  logic [2:0]  target;                 // requested sleep target
  logic        cmd_go;                 // request pulse
  logic        first_boot;             // soft-off not yet left since resume reset
  logic [31:0] limit_cnt;              // cycles since resume release
  logic        limit_hit;              // release bound reached
  sss_pkg::sss_pins_type next_pins;    // decoded pin levels

  // two flip-flop synchronisers for every pin input
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sync_a <= 11'h01C;  // trip, override and wake pins start idle, no false trip or wake
      sync_b <= 11'h01C;
    end else begin
      sync_a <= {strap_pins, bus_clock, rtc_tick, wake_event_n, power_button_ovr_n,
                 thermal_trip_n, core_power_good & regulator_power_good, resume_well_reset_n};
      sync_b <= sync_a;
    end
  end

  assign rw_ok   = sync_b[0];
  assign pg_ok   = sync_b[1];
  assign trip    = !sync_b[2];
  assign ovr     = !sync_b[3];
  assign wake    = !sync_b[4];
  assign strap_s = sync_b[10:7];

  // rising edges of the two slow clocks become one-cycle ticks
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rtc_prev <= 1'b0;
      bus_prev <= 1'b0;
    end else begin
      rtc_prev <= sync_b[5];
      bus_prev <= sync_b[6];
    end
  end

  assign rtc_pulse = sync_b[5] & !rtc_prev;
  assign bus_pulse = sync_b[6] & !bus_prev;

  // light-sleep steps run on the bus clock, all others on the real-time clock
  assign tick = (state inside {sss_pkg::ST_S1_PEND, sss_pkg::ST_S1_WAKE, sss_pkg::ST_S1_EXIT}) ?
                bus_pulse : rtc_pulse;

  // hibernate release width: stretched width from the two width bits, else short
  assign width = ctrl[sss_pkg::CTRL_STRETCH_BIT] ?
                 {3'h0, ctrl[sss_pkg::CTRL_WIDTH_LSB +: 2], 3'h7} + 8'h01 : sss_pkg::CNT_WIDTH_MIN;

  // register writes: configuration and sleep requests
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ctrl   <= sss_pkg::CTRL_RESET;
      target <= sss_pkg::TGT_LIGHT;
      cmd_go <= 1'b0;
    end else begin
      cmd_go <= 1'b0;
      if (wr_en && addr == sss_pkg::ADDR_CTRL) begin
        ctrl <= wr_data[5:0];
      end
      // request accepted only when awake and the target is known
      if (wr_en && addr == sss_pkg::ADDR_CMD && state == sss_pkg::ST_ON &&
          wr_data[2:0] >= sss_pkg::TGT_LIGHT && wr_data[2:0] <= sss_pkg::TGT_OFF) begin
        target <= wr_data[2:0];
        cmd_go <= 1'b1;
      end
    end
  end

  // register reads, answered the next cycle; unmapped reads give zero
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rd_data <= 32'h0000_0000;
    end else if (rd_en) begin
      case (addr)
        sss_pkg::ADDR_CTRL:   rd_data <= {26'h0, ctrl};
        sss_pkg::ADDR_CMD:    rd_data <= {29'h0, target};
        sss_pkg::ADDR_STATUS: rd_data <= {11'h0, first_boot, pg_ok, state};
        default:              rd_data <= 32'h0000_0000;
      endcase
    end else begin
      rd_data <= 32'h0000_0000;
    end
  end

  // bound on soft-off release after resume reset
  always_ff @(posedge clk_sys) begin
    if (!rstn || !rw_ok) begin
      limit_cnt <= 32'h0000_0000;
      limit_hit <= 1'b0;
    end else if (limit_cnt >= RELEASE_LIMIT - 32'h1) begin
      limit_hit <= 1'b1;
    end else begin
      limit_cnt <= limit_cnt + 32'h1;
    end
  end

  // first boot flag, dropped once soft-off is left
  always_ff @(posedge clk_sys) begin
    if (!rstn || !rw_ok) begin
      first_boot <= 1'b1;
    end else if (state == sss_pkg::ST_OFF && next_state != sss_pkg::ST_OFF) begin
      first_boot <= 1'b0;
    end
  end

  // next state
  always_comb begin
    next_state = state;
    case (state)
      sss_pkg::ST_OFF: begin
        if (first_boot && !ctrl[sss_pkg::CTRL_APL_BIT] && limit_hit) begin
          next_state = sss_pkg::ST_HIB_REL;
        end else if ((first_boot && !ctrl[sss_pkg::CTRL_APL_BIT]) || wake) begin
          next_state = sss_pkg::ST_OFF_WAKE;
        end
      end
      sss_pkg::ST_OFF_WAKE: begin
        if (cnt == sss_pkg::CNT_OFF_WAKE) next_state = sss_pkg::ST_HIB_REL;
      end
      sss_pkg::ST_HIB_REL: begin
        if (cnt >= width) next_state = sss_pkg::ST_RAM_REL;
      end
      sss_pkg::ST_RAM_REL: begin
        if (cnt == sss_pkg::CNT_RAM_REL) next_state = sss_pkg::ST_PWR_WAIT;
      end
      sss_pkg::ST_PWR_WAIT: begin
        if (pg_ok) next_state = sss_pkg::ST_STRAP;
      end
      sss_pkg::ST_STRAP: begin
        if (cnt == sss_pkg::CNT_STRAP) next_state = sss_pkg::ST_PLT;
      end
      sss_pkg::ST_PLT: begin
        if (cnt == sss_pkg::CNT_PLT) next_state = sss_pkg::ST_ON;
      end
      sss_pkg::ST_ON: begin
        if (cmd_go) next_state = sss_pkg::ST_GRANT;
      end
      sss_pkg::ST_GRANT: begin
        // the processor answers after any delay; wait without limit
        if (stop_grant_msg) begin
          next_state = (target == sss_pkg::TGT_LIGHT) ? sss_pkg::ST_S1_PEND : sss_pkg::ST_SUS_PEND;
        end
      end
      sss_pkg::ST_S1_PEND: begin
        if (cnt == sss_pkg::CNT_GRANT_BUS) next_state = sss_pkg::ST_S1;
      end
      sss_pkg::ST_S1: begin
        if (wake) next_state = sss_pkg::ST_S1_WAKE;
      end
      sss_pkg::ST_S1_WAKE: begin
        if (cnt == sss_pkg::CNT_WAKE_BUS) next_state = sss_pkg::ST_S1_EXIT;
      end
      sss_pkg::ST_S1_EXIT: begin
        if (cnt == sss_pkg::CNT_EXIT_BUS) next_state = sss_pkg::ST_ON;
      end
      sss_pkg::ST_SUS_PEND: begin
        if (cnt == sss_pkg::CNT_SUS) next_state = sss_pkg::ST_RST_PEND;
      end
      sss_pkg::ST_RST_PEND: begin
        if (cnt == sss_pkg::CNT_RST) next_state = sss_pkg::ST_RAM_PEND;
      end
      sss_pkg::ST_RAM_PEND: begin
        if (cnt == sss_pkg::CNT_STEP) next_state = sss_pkg::ST_RAM;
      end
      sss_pkg::ST_RAM: begin
        if (wake) begin
          next_state = sss_pkg::ST_RAM_WAKE;
        end else if (target >= sss_pkg::TGT_HIB && cnt == sss_pkg::CNT_STEP) begin
          next_state = sss_pkg::ST_HIB;
        end
      end
      sss_pkg::ST_RAM_WAKE: begin
        if (cnt == sss_pkg::CNT_RAM_WAKE) next_state = sss_pkg::ST_PWR_WAIT;
      end
      sss_pkg::ST_HIB: begin
        if (wake) begin
          next_state = sss_pkg::ST_HIB_REL;
        end else if (target == sss_pkg::TGT_OFF && cnt == sss_pkg::CNT_STEP) begin
          next_state = sss_pkg::ST_OFF;
        end
      end
      default: next_state = sss_pkg::ST_OFF;
    endcase
    // thermal trip and button override drop straight to soft-off
    if (trip || ovr) begin
      next_state = sss_pkg::ST_OFF;
    end
  end

  // state register, held in soft-off while the resume well is in reset
  always_ff @(posedge clk_sys) begin
    if (!rstn || !rw_ok) begin
      state <= sss_pkg::ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  // per-state tick counter, restarted on each state change
  always_ff @(posedge clk_sys) begin
    if (!rstn || !rw_ok) begin
      cnt <= 8'h00;
    end else if (next_state != state) begin
      cnt <= 8'h00;
    end else if (tick && cnt != 8'hFF) begin
      cnt <= cnt + 8'h01;
    end
  end

  // pin levels decoded from the next state so outputs come from flops
  always_comb begin
    next_pins                   = sss_pkg::PINS_RESET;
    next_pins.suspend_status_n  = next_state inside {sss_pkg::ST_PLT, sss_pkg::ST_ON, sss_pkg::ST_GRANT,
                                   sss_pkg::ST_S1_PEND, sss_pkg::ST_S1, sss_pkg::ST_S1_WAKE,
                                   sss_pkg::ST_S1_EXIT, sss_pkg::ST_SUS_PEND};
    next_pins.platform_reset_n  = next_state inside {sss_pkg::ST_ON, sss_pkg::ST_GRANT, sss_pkg::ST_S1_PEND,
                                   sss_pkg::ST_S1, sss_pkg::ST_S1_WAKE, sss_pkg::ST_S1_EXIT,
                                   sss_pkg::ST_SUS_PEND, sss_pkg::ST_RST_PEND};
    next_pins.sleep_ram_n       = !(next_state inside {sss_pkg::ST_OFF, sss_pkg::ST_OFF_WAKE,
                                   sss_pkg::ST_HIB_REL, sss_pkg::ST_RAM_REL, sss_pkg::ST_RAM,
                                   sss_pkg::ST_RAM_WAKE, sss_pkg::ST_HIB});
    next_pins.sleep_hibernate_n = !(next_state inside {sss_pkg::ST_OFF, sss_pkg::ST_OFF_WAKE,
                                   sss_pkg::ST_HIB_REL, sss_pkg::ST_HIB});
    next_pins.sleep_softoff_n   = !(next_state inside {sss_pkg::ST_OFF, sss_pkg::ST_OFF_WAKE});
    next_pins.stop_clock_n      = !(next_state inside {sss_pkg::ST_GRANT, sss_pkg::ST_S1_PEND, sss_pkg::ST_S1,
                                   sss_pkg::ST_S1_WAKE, sss_pkg::ST_S1_EXIT, sss_pkg::ST_SUS_PEND,
                                   sss_pkg::ST_RST_PEND, sss_pkg::ST_RAM_PEND, sss_pkg::ST_RAM,
                                   sss_pkg::ST_RAM_WAKE, sss_pkg::ST_HIB});
    next_pins.processor_sleep_n = !(next_state inside {sss_pkg::ST_S1, sss_pkg::ST_S1_WAKE});
  end

  // output flops; engine sleep and bus reset share their partners' decode
  always_ff @(posedge clk_sys) begin
    if (!rstn || !rw_ok) begin
      suspend_status_n    <= sss_pkg::PINS_RESET.suspend_status_n;
      platform_reset_n    <= sss_pkg::PINS_RESET.platform_reset_n;
      bus_reset_n         <= sss_pkg::PINS_RESET.platform_reset_n;
      sleep_ram_n         <= sss_pkg::PINS_RESET.sleep_ram_n;
      sleep_mgmt_engine_n <= sss_pkg::PINS_RESET.sleep_ram_n;
      sleep_hibernate_n   <= sss_pkg::PINS_RESET.sleep_hibernate_n;
      sleep_softoff_n     <= sss_pkg::PINS_RESET.sleep_softoff_n;
      stop_clock_n        <= sss_pkg::PINS_RESET.stop_clock_n;
      processor_sleep_n   <= sss_pkg::PINS_RESET.processor_sleep_n;
    end else begin
      suspend_status_n    <= next_pins.suspend_status_n;
      platform_reset_n    <= next_pins.platform_reset_n;
      bus_reset_n         <= next_pins.platform_reset_n;
      sleep_ram_n         <= next_pins.sleep_ram_n;
      sleep_mgmt_engine_n <= next_pins.sleep_ram_n;
      sleep_hibernate_n   <= next_pins.sleep_hibernate_n;
      sleep_softoff_n     <= next_pins.sleep_softoff_n;
      stop_clock_n        <= next_pins.stop_clock_n;
      processor_sleep_n   <= next_pins.processor_sleep_n;
    end
  end

  // suspend clock toggles on each real-time tick once the resume well is up
  always_ff @(posedge clk_sys) begin
    if (!rstn || !rw_ok) begin
      suspend_clock <= 1'b0;
    end else if (rtc_pulse) begin
      suspend_clock <= !suspend_clock;
    end
  end

  // straps caught as suspend status releases
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      strap_value   <= 4'h0;
      strap_capture <= 1'b0;
    end else begin
      strap_capture <= 1'b0;
      if (state == sss_pkg::ST_STRAP && next_state == sss_pkg::ST_PLT) begin
        strap_value   <= strap_s;
        strap_capture <= 1'b1;
      end
    end
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence seq_cpu_awake;
    $rose(processor_sleep_n);
  endsequence

  sequence seq_clock_held;
    !stop_clock_n [*8];
  endsequence

  mgmt_follow_a: assert property (sleep_mgmt_engine_n == sleep_ram_n)
    else $error("engine sleep differs from ram sleep");
  bus_reset_pair_a: assert property (bus_reset_n == platform_reset_n)
    else $error("bus reset differs from platform reset");
  thermal_shut_a: assert property ($fell(thermal_trip_n) |-> ##[1:18]
    (!sleep_ram_n && !sleep_hibernate_n && !sleep_softoff_n))
    else $error("thermal trip did not assert sleep levels in time");
  stop_hold_a: assert property (seq_cpu_awake |-> seq_clock_held)
    else $error("stop clock released too soon after processor sleep");
  grant_first_a: assert property ($fell(processor_sleep_n) |-> !stop_clock_n &&
    $past(cnt) >= 8'h3C && $past(cnt) <= 8'h3F)
    else $error("processor sleep outside its window after grant");
  resume_hold_a: assert property (!rw_ok |=> state == sss_pkg::ST_OFF && cnt == 8'h00)
    else $error("sequencer not held off during resume reset");
  hib_stagger_a: assert property ($fell(sleep_hibernate_n) |-> !sleep_ram_n)
    else $error("hibernate sleep asserted before ram sleep");
  softoff_stagger_a: assert property ($fell(sleep_softoff_n) |-> !sleep_hibernate_n && !sleep_ram_n)
    else $error("soft-off sleep asserted before hibernate sleep");
  reset_order_a: assert property ($fell(platform_reset_n) |-> !suspend_status_n)
    else $error("platform reset asserted with suspend status idle");
  plt_release_a: assert property ($rose(platform_reset_n) |-> suspend_status_n && $past(suspend_status_n))
    else $error("platform reset released before suspend status");
  ram_release_a: assert property ($rose(sleep_ram_n) |-> sleep_hibernate_n && $past(sleep_hibernate_n))
    else $error("ram sleep released before hibernate sleep");

endmodule

// *** test/sss_partner.sv ***
// processor and power rail model facing the sleep sequencer
module sss_partner (
  input  wire logic clk_sys,        // system clock
  input  wire logic stop_clock_n,   // stop clock from the block
  input  wire logic sleep_ram_n,    // ram sleep level from the block
  output logic      stop_grant_msg, // one-cycle grant pulse
  output logic      power_good      // core and regulator rails good
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned wait_cnt;  // cycles since stop clock asserted

  // processor grants some time after stop clock, once per request
  always_ff @(posedge clk_sys) begin
    wait_cnt       <= stop_clock_n ? 0 : wait_cnt + 1;
    stop_grant_msg <= (wait_cnt == 20);
  end

  // rails are switched by the ram sleep level
  always_ff @(posedge clk_sys) power_good <= sleep_ram_n;
endmodule

// *** test/sss_sequencer_tb.sv ***
// self-checking bench for the sleep state sequencer
module sss_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rstn, resume_well_reset_n, core_power_good, thermal_trip_n, wake_event_n, rtc_tick,
        bus_clock, stop_grant_msg, wr_en, rd_en, ovr_n, suspend_status_n, platform_reset_n, bus_reset_n,
        sleep_ram_n, sleep_hibernate_n, sleep_softoff_n, sleep_mgmt_engine_n, processor_sleep_n,
        stop_clock_n, suspend_clock, strap_capture;
  logic [3:0]  addr, strap_value;
  logic [31:0] wr_data, rd_data, q;
  logic [7:0]  div;                              // slow clock divider
  int          n_mismatch, tests_run, ticks, cyc;

  sss_sequencer #(.RELEASE_LIMIT(200)) dut_u (.clk_sys, .rstn, .resume_well_reset_n, .core_power_good,
    .regulator_power_good(core_power_good), .thermal_trip_n, .power_button_ovr_n(ovr_n), .wake_event_n,
    .rtc_tick, .bus_clock, .strap_pins(4'hA), .stop_grant_msg, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
    .suspend_status_n, .platform_reset_n, .bus_reset_n, .sleep_ram_n, .sleep_hibernate_n,
    .sleep_softoff_n, .sleep_mgmt_engine_n, .processor_sleep_n, .stop_clock_n, .suspend_clock,
    .strap_value, .strap_capture);
  sss_partner part_u (.clk_sys, .stop_clock_n, .sleep_ram_n, .stop_grant_msg, .power_good(core_power_good));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // real-time tick every 8 cycles, bus clock every 4, hang watchdog
  always @(posedge clk_sys) begin
    div       <= div + 8'h01;
    rtc_tick  <= div[2];
    bus_clock <= div[1];
    cyc       <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end
  always @(posedge rtc_tick) ticks++;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // wait for a level, then judge the tick distance from the call
  task automatic span(ref logic s, input logic v, input int lo, input int hi, input string nm);
    int t0;
    t0 = ticks;
    for (int i = 0; i < 2000 && s !== v; i++) @(posedge clk_sys) #1;
    chk(nm, s === v && ticks - t0 >= lo && ticks - t0 <= hi, 1'b1);
  endtask

  // one register cycle, read data taken in the cycle after the strobe
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_sys);
    {addr, wr_data, wr_en, rd_en} <= {a, d, w, !w};
    @(posedge clk_sys);
    {wr_en, rd_en} <= 2'b00;
    #1 r = rd_data;
  endtask

  task automatic boot_test();
    @(posedge clk_sys) resume_well_reset_n <= 1'b1;
    span(sleep_softoff_n, 1'b1, 1, 10, "softoff release");
    span(sleep_hibernate_n, 1'b1, 1, 3, "hibernate release");
    span(sleep_ram_n, 1'b1, 1, 4, "ram release");
    chk("engine sleep", sleep_mgmt_engine_n, 1'b1);
    span(suspend_status_n, 1'b1, 32, 38, "suspend release");
    chk("straps", strap_value, 4'hA);
    chk("strap pulse", strap_capture, 1'b1);
    span(platform_reset_n, 1'b1, 2, 3, "platform release");
    chk("bus reset", bus_reset_n, 1'b1);
    q[0] = suspend_clock;
    repeat (8) @(posedge clk_sys);
    #1 chk("suspend clock", suspend_clock, !q[0]);
    $display("boot test done");
  endtask

  task automatic ram_test();
    bus(1'b1, 4'h4, 32'h2, q);
    span(stop_clock_n, 1'b0, 0, 1, "stop clock");
    span(suspend_status_n, 1'b0, 2, 8, "suspend assert");
    span(platform_reset_n, 1'b0, 7, 17, "reset assert");
    chk("bus reset", bus_reset_n, 1'b0);
    span(sleep_ram_n, 1'b0, 1, 2, "ram assert");
    chk("hibernate idle", sleep_hibernate_n, 1'b1);
    @(posedge clk_sys) wake_event_n <= 1'b0;
    span(sleep_ram_n, 1'b1, 0, 2, "ram wake");
    chk("engine wake", sleep_mgmt_engine_n, 1'b1);
    @(posedge clk_sys) wake_event_n <= 1'b1;
    span(suspend_status_n, 1'b1, 32, 38, "resume release");
    span(platform_reset_n, 1'b1, 2, 3, "platform again");
    $display("ram test done");
  endtask

  task automatic light_test();
    bus(1'b1, 4'h4, 32'h1, q);
    span(processor_sleep_n, 1'b0, 32, 36, "processor sleep");
    @(posedge clk_sys) wake_event_n <= 1'b0;
    span(processor_sleep_n, 1'b1, 0, 3, "processor wake");
    @(posedge clk_sys) wake_event_n <= 1'b1;
    span(stop_clock_n, 1'b1, 4, 6, "stop clock release");
    $display("light test done");
  endtask

  task automatic ovr_test();
    @(posedge clk_sys) ovr_n <= 1'b0;
    span(sleep_softoff_n, 1'b0, 0, 1, "override");
    chk("override levels", {sleep_ram_n, sleep_hibernate_n}, 2'h0);
    @(posedge clk_sys) {ovr_n, wake_event_n} <= 2'b10;
    span(sleep_softoff_n, 1'b1, 1, 10, "softoff wake");
    @(posedge clk_sys) wake_event_n <= 1'b1;
    span(platform_reset_n, 1'b1, 40, 46, "override recovery");
    $display("override test done");
  endtask

  task automatic trip_test();
    int n;
    @(posedge clk_sys) thermal_trip_n <= 1'b0;
    for (n = 0; n < 40 && sleep_softoff_n !== 1'b0; n++) @(posedge clk_sys) #1;
    chk("trip delay", n <= 12, 1'b1);
    chk("trip levels", {sleep_ram_n, sleep_hibernate_n, platform_reset_n}, 3'h0);
    bus(1'b0, 4'h8, 32'h0, q);
    chk("status off", q[18:0], sss_pkg::ST_OFF);
    bus(1'b0, 4'hC, 32'h0, q);
    chk("unmapped", q, 32'h0);
    $display("trip test done");
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    {rstn, resume_well_reset_n, wr_en, rd_en, addr, wr_data, div, rtc_tick, bus_clock} = '0;
    {thermal_trip_n, wake_event_n, ovr_n, cyc, ticks, n_mismatch, tests_run} = {3'b111, 128'h0};
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    boot_test();
    ram_test();
    light_test();
    ovr_test();
    trip_test();
    test_done();
  end
endmodule
